// ### design/timer_capture_common_logic.sv
// 16-bit capture timer: pin routing, count source, filter, buffering, cutoff, capture
`timescale 1ns/1ns
`default_nettype none
`include "timer_capture_cfg.svh"

module timer_capture_common_logic (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // channel pins
  input  wire logic        chan_a_pin_i,
  output logic             chan_a_pin_o,
  output logic             chan_a_pin_oe_o,
  input  wire logic        chan_b_pin_i,
  output logic             chan_b_pin_o,
  output logic             chan_b_pin_oe_o,
  input  wire logic [2:0]  chan_c_pin_i,
  output logic      [2:0]  chan_c_pin_o,
  output logic      [2:0]  chan_c_pin_oe_o,
  input  wire logic [2:0]  chan_d_pin_i,
  output logic      [2:0]  chan_d_pin_o,
  output logic      [2:0]  chan_d_pin_oe_o,
  // trigger, clock and cutoff inputs
  input  wire logic        trigger_pin_i,
  input  wire logic        external_count_clock_pin_i,
  input  wire logic        external_count_clock_dir_in_i,
  input  wire logic        cutoff_interrupt_pin_n_i,
  // on-chip oscillator ticks and slow capture source
  input  wire logic        fast_osc_enable_i,
  input  wire logic        osc_fast_40m_i,
  input  wire logic        osc_fast_divided_i,
  input  wire logic        osc_slow_capture_source_i,
  // interrupt request pulse
  output logic             irq_o
);

  // bus slave state
  timer_capture_pkg::bus_state_t bus_state_q;
  timer_capture_pkg::bus_req_t   req_q;
  logic        hready_q;
  logic [31:0] hrdata_q;

  // software registers
  logic [7:0]  mode_q;
  logic [7:0]  ctrl1_q;
  logic [7:0]  stat_q;
  logic [7:0]  ioctl0_q;
  logic [7:0]  ioctl1_q;
  logic [7:0]  filter_q;
  logic [7:0]  outen_q;
  logic [7:0]  route_q;
  logic [15:0] cnt_q;
  logic [15:0] gen_q [4];

  // timing and pin state
  logic [4:0]  pre_q;
  logic        ext_q;
  logic        ext_prev_q;
  logic        slow_q;
  logic        slow_prev_q;
  logic [4:0]  lvl_q;
  logic [4:0]  lvl_prev_q;
  logic [2:0]  samp_q [5];
  logic [3:0]  out_lvl_q;
  logic [3:0]  drive_q;
  logic [2:0]  c_oe_q;
  logic [2:0]  d_oe_q;
  logic        irq_q;

  // ---------------- bus decode ----------------
  wire        accept  = hsel_i & hready_i & htrans_i[1] & (bus_state_q == timer_capture_pkg::BUS_ADDR);
  wire        do_acc  = (bus_state_q == timer_capture_pkg::BUS_DATA);
  wire        wr_en   = do_acc & req_q.write;
  wire [7:0]  wb      = hwdata_i[7:0];
  wire [15:0] wh      = hwdata_i[15:0];
  wire        wr_mode   = wr_en & (req_q.addr == `BYTE_ADDR(`IDX_MODE));
  wire        wr_ctrl1  = wr_en & (req_q.addr == `BYTE_ADDR(`IDX_CTRL1));
  wire        wr_stat   = wr_en & (req_q.addr == `BYTE_ADDR(`IDX_STATUS));
  wire        wr_ioctl0 = wr_en & (req_q.addr == `BYTE_ADDR(`IDX_IOCTL0));
  wire        wr_ioctl1 = wr_en & (req_q.addr == `BYTE_ADDR(`IDX_IOCTL1));
  wire        wr_cnt    = wr_en & (req_q.addr == `BYTE_ADDR(`IDX_COUNTER));
  wire        wr_filter = wr_en & (req_q.addr == `BYTE_ADDR(`IDX_FILTER));
  wire        wr_outen  = wr_en & (req_q.addr == `BYTE_ADDR(`IDX_OUTEN));
  wire        wr_route  = wr_en & (req_q.addr == `BYTE_ADDR(`IDX_ROUTE));
  wire [3:0]  wr_gen;
  assign wr_gen[0] = wr_en & (req_q.addr == `BYTE_ADDR(`IDX_GEN_A));
  assign wr_gen[1] = wr_en & (req_q.addr == `BYTE_ADDR(`IDX_GEN_B));
  assign wr_gen[2] = wr_en & (req_q.addr == `BYTE_ADDR(`IDX_GEN_C));
  assign wr_gen[3] = wr_en & (req_q.addr == `BYTE_ADDR(`IDX_GEN_D));

  // unmapped addresses read as zero and ignore writes
  wire [15:0] rd_mux =
    (req_q.addr == `BYTE_ADDR(`IDX_MODE))    ? {8'h00, mode_q} :
    (req_q.addr == `BYTE_ADDR(`IDX_CTRL1))   ? {8'h00, ctrl1_q} :
    (req_q.addr == `BYTE_ADDR(`IDX_STATUS))  ? {8'h00, stat_q} :
    (req_q.addr == `BYTE_ADDR(`IDX_IOCTL0))  ? {8'h00, ioctl0_q | `RONE_IOCTL0} :
    (req_q.addr == `BYTE_ADDR(`IDX_IOCTL1))  ? {8'h00, ioctl1_q} :
    (req_q.addr == `BYTE_ADDR(`IDX_COUNTER)) ? cnt_q :
    (req_q.addr == `BYTE_ADDR(`IDX_GEN_A))   ? gen_q[0] :
    (req_q.addr == `BYTE_ADDR(`IDX_GEN_B))   ? gen_q[1] :
    (req_q.addr == `BYTE_ADDR(`IDX_GEN_C))   ? gen_q[2] :
    (req_q.addr == `BYTE_ADDR(`IDX_GEN_D))   ? gen_q[3] :
    (req_q.addr == `BYTE_ADDR(`IDX_FILTER))  ? {8'h00, filter_q} :
    (req_q.addr == `BYTE_ADDR(`IDX_OUTEN))   ? {8'h00, outen_q | `RONE_OUTEN} :
    (req_q.addr == `BYTE_ADDR(`IDX_ROUTE))   ? {8'h00, route_q} : 16'h0000;

  // one wait state on every transfer keeps read data straight from a flop
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      bus_state_q <= timer_capture_pkg::BUS_ADDR;
      req_q       <= '0;
      hready_q    <= 1'b1;
      hrdata_q    <= 32'h0000_0000;
    end
    else
    begin
      case (bus_state_q)
        timer_capture_pkg::BUS_ADDR:
        begin
          if (accept)
          begin
            req_q.write <= hwrite_i;
            req_q.addr  <= haddr_i[13:0];
            hready_q    <= 1'b0;
            bus_state_q <= timer_capture_pkg::BUS_DATA;
          end
        end
        timer_capture_pkg::BUS_DATA:
        begin
          hrdata_q    <= req_q.write ? 32'h0000_0000 : {16'h0000, rd_mux};
          hready_q    <= 1'b1;
          bus_state_q <= timer_capture_pkg::BUS_ADDR;
        end
        default:
        begin
          hready_q    <= 1'b1;
          bus_state_q <= timer_capture_pkg::BUS_ADDR;
        end
      endcase
    end
  end

  // ---------------- count source ----------------
  wire [2:0] src_sel = ctrl1_q[`CTRL1_SRC_LO +: 3];
  wire       ext_tick = ext_q & ~ext_prev_q & external_count_clock_dir_in_i;
  // oscillator ticks count only while the oscillator is switched on
  wire       src_tick =
    (src_sel == `SRC_F1)    ? 1'b1 :
    (src_sel == `SRC_F2)    ? pre_q[0] :
    (src_sel == `SRC_F4)    ? (&pre_q[1:0]) :
    (src_sel == `SRC_F8)    ? (&pre_q[2:0]) :
    (src_sel == `SRC_F32)   ? (&pre_q) :
    (src_sel == `SRC_EXT)   ? ext_tick :
    (src_sel == `SRC_OSC40) ? (osc_fast_40m_i & fast_osc_enable_i) :
                              (osc_fast_divided_i & fast_osc_enable_i);

  wire [1:0] fclk_sel = filter_q[`FILT_CLK_LO +: 2];
  wire       samp_tick =
    (fclk_sel == `FCLK_F32) ? (&pre_q) :
    (fclk_sel == `FCLK_F8)  ? (&pre_q[2:0]) :
    (fclk_sel == `FCLK_F1)  ? 1'b1 : src_tick;

  // ---------------- pin routing ----------------
  wire [1:0] route_c = route_q[`ROUTE_C_LO +: 2];
  wire [1:0] route_d = route_q[`ROUTE_D_LO +: 2];
  wire       route_c_lvl = (route_c == 2'h1) ? chan_c_pin_i[0] :
                           (route_c == 2'h2) ? chan_c_pin_i[1] :
                           (route_c == 2'h3) ? chan_c_pin_i[2] : 1'b0;
  wire       route_d_lvl = (route_d == 2'h1) ? chan_d_pin_i[0] :
                           (route_d == 2'h2) ? chan_d_pin_i[1] :
                           (route_d == 2'h3) ? chan_d_pin_i[2] : 1'b0;
  wire [4:0] raw_in = {trigger_pin_i, route_d_lvl, route_c_lvl, chan_b_pin_i, chan_a_pin_i};

  // ---------------- channel configuration ----------------
  timer_capture_pkg::chan_cfg_t cfg [4];
  assign cfg[0] = {ioctl0_q[`IOCTL_EDGE0 +: 2], ioctl0_q[`IOCTL_MODE0]};
  assign cfg[1] = {ioctl0_q[`IOCTL_EDGE1 +: 2], ioctl0_q[`IOCTL_MODE1]};
  assign cfg[2] = {ioctl1_q[`IOCTL_EDGE0 +: 2], ioctl1_q[`IOCTL_MODE0]};
  assign cfg[3] = {ioctl1_q[`IOCTL_EDGE1 +: 2], ioctl1_q[`IOCTL_MODE1]};

  wire       run   = mode_q[`MODE_START];
  wire       cnt_step = run & src_tick;
  wire       bufc  = mode_q[`MODE_BUFC];
  wire       bufd  = mode_q[`MODE_BUFD];
  wire       cclr  = ctrl1_q[`CTRL1_CCLR];
  wire       ovf   = cnt_step & (cnt_q == 16'hFFFF);
  wire       cutoff_now = outen_q[`OUTEN_CUTOFF] & ~cutoff_interrupt_pin_n_i;

  wire [3:0] cap_fire;
  wire [3:0] match;
  wire [3:0] cmp_flag;
  wire [1:0] tsel = mode_q[`MODE_TRIG_LO +: 2];
  wire       trig_rise = lvl_q[4] & ~lvl_prev_q[4];
  wire       trig_fall = ~lvl_q[4] & lvl_prev_q[4];
  wire       trig_evt = ((tsel == `TRIG_RISE) & trig_rise) | ((tsel == `TRIG_FALL) & trig_fall) |
                        ((tsel == `TRIG_BOTH) & (trig_rise | trig_fall));

  // channel A may watch the slow oscillator instead of its pin
  wire       a_srcpin = ioctl0_q[`IOCTL_SRC0];
  wire       a_now    = a_srcpin ? lvl_q[0] : slow_q;
  wire       a_prev   = a_srcpin ? lvl_prev_q[0] : slow_prev_q;

  genvar j;
  generate
    // digital filter on four channels and the trigger
    for (j = 0; j < 5; j++)
    begin : g_filt
      wire flt_on = filter_q[j];
      wire agree  = (samp_q[j] == 3'h7) | (samp_q[j] == 3'h0);
      always_ff @(posedge mclk_i)
      begin
        if (reset_i)
        begin
          samp_q[j]     <= 3'h0;
          lvl_q[j]      <= 1'b0;
          lvl_prev_q[j] <= 1'b0;
        end
        else
        begin
          if (samp_tick)
            samp_q[j] <= {samp_q[j][1:0], raw_in[j]};
          if (!flt_on)
            lvl_q[j] <= raw_in[j];
          else if (agree)
            lvl_q[j] <= samp_q[j][0];
          lvl_prev_q[j] <= lvl_q[j];
        end
      end
    end

    // edge detection, compare match and flag sources per channel
    for (j = 0; j < 4; j++)
    begin : g_chan
      wire now_l  = (j == 0) ? a_now : lvl_q[j];
      wire prev_l = (j == 0) ? a_prev : lvl_prev_q[j];
      wire rise   = now_l & ~prev_l;
      wire fall   = ~now_l & prev_l;
      wire edge_ok = ((cfg[j].edge_sel == `EDGE_RISE) & rise) |
                     ((cfg[j].edge_sel == `EDGE_FALL) & fall) |
                     ((cfg[j].edge_sel == `EDGE_BOTH) & (rise | fall));
      assign cap_fire[j] = cfg[j].cap_mode & edge_ok;
      assign match[j]    = cnt_step & (cnt_q == gen_q[j]);
      assign cmp_flag[j] = ~cfg[j].cap_mode & match[j];
    end
  endgenerate

  // ---------------- general register loads ----------------
  wire        ld_a_buf = ~cfg[0].cap_mode & bufc & match[0];
  wire        ld_b_buf = ~cfg[1].cap_mode & bufd & match[1];
  wire        ld_b_pwm2 = mode_q[`MODE_PWM2] & (match[0] | trig_evt);
  wire [3:0]  ld_en;
  wire [15:0] ld_val [4];
  assign ld_en[0]  = cap_fire[0] | ld_a_buf;
  assign ld_val[0] = cap_fire[0] ? cnt_q : gen_q[2];
  assign ld_en[1]  = cap_fire[1] | ld_b_buf | ld_b_pwm2;
  assign ld_val[1] = cap_fire[1] ? cnt_q : gen_q[3];
  // with buffering on, a capture on A or B pushes the old value to C or D
  assign ld_en[2]  = bufc ? (cfg[0].cap_mode & cap_fire[0]) : cap_fire[2];
  assign ld_val[2] = bufc ? gen_q[0] : cnt_q;
  assign ld_en[3]  = bufd ? (cfg[1].cap_mode & cap_fire[1]) : cap_fire[3];
  assign ld_val[3] = bufd ? gen_q[1] : cnt_q;

  generate
    for (j = 0; j < 4; j++)
    begin : g_gen
      always_ff @(posedge mclk_i)
      begin
        if (reset_i)
          gen_q[j] <= `RST_GEN;
        else if (wr_gen[j])
          gen_q[j] <= wh;
        else if (ld_en[j])
          gen_q[j] <= ld_val[j];
      end
    end
  endgenerate

  // ---------------- counter ----------------
  wire        clr_cap = cclr & cap_fire[0];
  wire        clr_cmp = cclr & cmp_flag[0];
  wire [15:0] cnt_d = wr_cnt ? wh :
                      clr_cap ? 16'h0000 :
                      cnt_step ? (clr_cmp ? 16'h0000 : cnt_q + 16'h0001) : cnt_q;

  // ---------------- status and output disable ----------------
  wire [3:0] ch_set  = cap_fire | cmp_flag;
  wire [7:0] stat_set = {ovf, 3'h0, ch_set};
  wire [7:0] stat_clr = wr_stat ? ~wb : 8'h00;
  // hardware set wins over a same-cycle software clear
  wire [7:0] stat_d  = (stat_q & ~stat_clr) | stat_set;
  wire [7:0] outen_w = wr_outen ? (wb & `WMASK_OUTEN) : outen_q;
  wire [7:0] outen_d = cutoff_now ? (outen_w | 8'h0F) : outen_w;
  // cutoff also gates drive directly so pins release on the next edge
  wire [3:0] drive_d = ~{cfg[3].cap_mode, cfg[2].cap_mode, cfg[1].cap_mode, cfg[0].cap_mode} &
                       ~outen_q[3:0] & {4{~cutoff_now}};
  wire [3:0] out_lvl_d = out_lvl_q ^ cmp_flag;
  // only the routed alternate pin is driven; code 00 leaves all three free
  wire [2:0] c_oe_d = {3{drive_d[2]}} & {route_c == 2'h3, route_c == 2'h2, route_c == 2'h1};
  wire [2:0] d_oe_d = {3{drive_d[3]}} & {route_d == 2'h3, route_d == 2'h2, route_d == 2'h1};

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      mode_q    <= 8'h00;
      ctrl1_q   <= 8'h00;
      stat_q    <= 8'h00;
      ioctl0_q  <= `RST_IOCTL & `WMASK_IOCTL0;
      ioctl1_q  <= `RST_IOCTL;
      filter_q  <= 8'h00;
      outen_q   <= `RST_OUTEN & `WMASK_OUTEN;
      route_q   <= 8'h00;
      cnt_q     <= 16'h0000;
    end
    else
    begin
      if (wr_mode)
        mode_q <= wb;
      if (wr_ctrl1)
        ctrl1_q <= wb;
      if (wr_ioctl0)
        ioctl0_q <= wb & `WMASK_IOCTL0;
      if (wr_ioctl1)
        ioctl1_q <= wb;
      if (wr_filter)
        filter_q <= wb & `WMASK_FILTER;
      if (wr_route)
        route_q <= wb & `WMASK_ROUTE;
      stat_q  <= stat_d;
      outen_q <= outen_d;
      cnt_q   <= cnt_d;
    end
  end

  // ---------------- pin and interrupt flops ----------------
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      pre_q       <= 5'h00;
      ext_q       <= 1'b0;
      ext_prev_q  <= 1'b0;
      slow_q      <= 1'b0;
      slow_prev_q <= 1'b0;
      out_lvl_q   <= 4'h0;
      drive_q     <= 4'h0;
      c_oe_q      <= 3'h0;
      d_oe_q      <= 3'h0;
      irq_q       <= 1'b0;
    end
    else
    begin
      pre_q       <= pre_q + 5'h01;
      ext_q       <= external_count_clock_pin_i;
      ext_prev_q  <= ext_q;
      slow_q      <= osc_slow_capture_source_i;
      slow_prev_q <= slow_q;
      out_lvl_q   <= out_lvl_d;
      drive_q     <= drive_d;
      c_oe_q      <= c_oe_d;
      d_oe_q      <= d_oe_d;
      irq_q       <= (|ch_set) | ovf;
    end
  end

  // ---------------- outputs ----------------
  assign hrdata_o        = hrdata_q;
  assign hreadyout_o     = hready_q;
  assign hresp_o         = 1'b0;
  assign chan_a_pin_o    = out_lvl_q[0];
  assign chan_a_pin_oe_o = drive_q[0];
  assign chan_b_pin_o    = out_lvl_q[1];
  assign chan_b_pin_oe_o = drive_q[1];
  assign chan_c_pin_o    = {3{out_lvl_q[2]}};
  assign chan_d_pin_o    = {3{out_lvl_q[3]}};
  assign chan_c_pin_oe_o = c_oe_q;
  assign chan_d_pin_oe_o = d_oe_q;
  assign irq_o           = irq_q;

endmodule
`default_nettype wire

// ### design/timer_capture_cfg.svh
// register map, field positions, reset values and codes of the capture timer
`ifndef TIMER_CAPTURE_CFG_SVH
`define TIMER_CAPTURE_CFG_SVH

// register indices; byte address is the index times four
`define IDX_MODE     12'h120
`define IDX_CTRL1    12'h121
`define IDX_STATUS   12'h123
`define IDX_IOCTL0   12'h124
`define IDX_IOCTL1   12'h125
`define IDX_COUNTER  12'h126
`define IDX_GEN_A    12'h128
`define IDX_GEN_B    12'h12A
`define IDX_GEN_C    12'h12C
`define IDX_GEN_D    12'h12E
`define IDX_FILTER   12'h131
`define IDX_OUTEN    12'h132
`define IDX_ROUTE    12'h183
`define BYTE_ADDR(i) {(i), 2'b00}

// reset values
`define RST_IOCTL    8'h88
`define RST_OUTEN    8'h7F
`define RST_GEN      16'hFFFF

// writable bits and bits that read as one
`define WMASK_ROUTE  8'h77
`define WMASK_IOCTL0 8'h7F
`define WMASK_FILTER 8'hDF
`define WMASK_OUTEN  8'h8F
`define RONE_IOCTL0  8'h80
`define RONE_OUTEN   8'h70

// field positions
`define MODE_START   0
`define MODE_PWM2    1
`define MODE_BUFC    2
`define MODE_BUFD    3
`define MODE_TRIG_LO 4
`define CTRL1_CCLR   7
`define CTRL1_SRC_LO 4
`define STAT_OVF     7
`define OUTEN_CUTOFF 7
`define FILT_CLK_LO  6
`define FILT_TRIG    4
`define ROUTE_C_LO   0
`define ROUTE_D_LO   4
`define IOCTL_EDGE0  0
`define IOCTL_MODE0  2
`define IOCTL_SRC0   3
`define IOCTL_EDGE1  4
`define IOCTL_MODE1  6

// count source codes
`define SRC_F1       3'h0
`define SRC_F2       3'h1
`define SRC_F4       3'h2
`define SRC_F8       3'h3
`define SRC_F32      3'h4
`define SRC_EXT      3'h5
`define SRC_OSC40    3'h6
`define SRC_OSCF     3'h7

// capture edge, filter clock and trigger codes
`define EDGE_RISE    2'h0
`define EDGE_FALL    2'h1
`define EDGE_BOTH    2'h2
`define FCLK_F32     2'h0
`define FCLK_F8      2'h1
`define FCLK_F1      2'h2
`define TRIG_RISE    2'h1
`define TRIG_FALL    2'h2
`define TRIG_BOTH    2'h3
`define ROUTE_NONE   2'h0

`endif

// ### design/timer_capture_pkg.sv
// types shared by the capture timer
`default_nettype none
package timer_capture_pkg;

  typedef enum logic {BUS_ADDR, BUS_DATA} bus_state_t;

  typedef struct packed {
    logic        write;
    logic [13:0] addr;
  } bus_req_t;

  typedef struct packed {
    logic [1:0] edge_sel;
    logic       cap_mode;
  } chan_cfg_t;

endpackage
`default_nettype wire

// ### testbench/timer_capture_properties.sv
// concurrent checks on the capture timer ports
`timescale 1ns/1ns
`default_nettype none
`include "timer_capture_cfg.svh"
module timer_capture_properties (
  // clock, reset and bus
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  // pin enables and cutoff
  input wire logic        chan_a_pin_oe_o,
  input wire logic        chan_b_pin_oe_o,
  input wire logic [2:0]  chan_c_pin_oe_o,
  input wire logic [2:0]  chan_d_pin_oe_o,
  input wire logic        cutoff_interrupt_pin_n_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic        dp_q;
  logic        wr_q;
  logic [13:0] adr_q;
  logic [7:0]  route_q;
  logic [3:0]  dis_q;
  logic        cut_q;
  wire         take  = hsel_i && hready_i && htrans_i[1] && hreadyout_o;
  wire         wdp   = dp_q && wr_q && !hreadyout_o;
  wire         rdp   = dp_q && !wr_q && hreadyout_o;
  wire         cut   = cut_q && !cutoff_interrupt_pin_n_i;
  wire  [3:0]  c_msk = 4'h1 << route_q[1:0];
  wire  [3:0]  d_msk = 4'h1 << route_q[5:4];
  wire  [3:0]  oe_v  = {|chan_d_pin_oe_o, |chan_c_pin_oe_o, chan_b_pin_oe_o, chan_a_pin_oe_o};
  // shadow of routing and output enables, rebuilt from bus writes
  always_ff @(posedge mclk_i)
  begin
    if (take)
    begin
      adr_q <= haddr_i[13:0];
      wr_q  <= hwrite_i;
    end
  end
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      dp_q    <= 1'b0;
      route_q <= 8'h00;
      dis_q   <= 4'hF;
      cut_q   <= 1'b0;
    end
    else
    begin
      if (take || hreadyout_o)
        dp_q <= take;
      if (wdp && adr_q == `BYTE_ADDR(`IDX_ROUTE))
        route_q <= hwdata_i[7:0];
      if (wdp && adr_q == `BYTE_ADDR(`IDX_OUTEN))
      begin
        cut_q <= hwdata_i[7];
        dis_q <= hwdata_i[3:0];
      end
      if (cut)
        dis_q <= 4'hF;
    end
  end
  sequence one_wait;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  bus_wait_a: assert property (take |=> one_wait)
    else $error("bus answer not after one wait state");
  okay_resp_a: assert property (hresp_o == 1'b0)
    else $error("bus response not okay");
  route_read_a: assert property (rdp && adr_q == `BYTE_ADDR(`IDX_ROUTE) |-> hrdata_o == {24'h0, route_q & 8'h77})
    else $error("routing read back wrong");
  c_route_a: assert property (route_q == $past(route_q) |-> (chan_c_pin_oe_o & ~c_msk[3:1]) == 3'h0)
    else $error("channel c drives an unrouted pin");
  d_route_a: assert property (route_q == $past(route_q) |-> (chan_d_pin_oe_o & ~d_msk[3:1]) == 3'h0)
    else $error("channel d drives an unrouted pin");
  oe_disable_a: assert property ((dis_q & $past(dis_q) & oe_v) == 4'h0)
    else $error("pin driven while its output is disabled");
  cutoff_oe_a: assert property (cut |-> ##[1:2] oe_v == 4'h0)
    else $error("outputs not released after cutoff");
  outen_read_a: assert property (rdp && adr_q == `BYTE_ADDR(`IDX_OUTEN) |-> hrdata_o[7:0] == {cut_q, 3'h7, dis_q})
    else $error("output enable read back wrong");
endmodule
bind timer_capture_common_logic timer_capture_properties i_props (
  .mclk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i,
  .hrdata_o, .hreadyout_o, .hresp_o, .chan_a_pin_oe_o, .chan_b_pin_oe_o,
  .chan_c_pin_oe_o, .chan_d_pin_oe_o, .cutoff_interrupt_pin_n_i
);
`default_nettype wire

// ### testbench/ext_signal_model.sv
// external capture, trigger, cutoff and count-clock sources
`timescale 1ns/1ns
`default_nettype none
`include "timer_capture_cfg.svh"
module ext_signal_model (
  input  wire logic       mclk_i,
  // levels: 0 a, 1 b, 2 routed c, 3 d, 4 slow osc, 5 cutoff low-active, 6 trigger
  output var  logic [6:0] lvl_o,
  output var  logic       ext_clk_o,
  output var  logic       osc40_o,
  output var  logic       oscf_o
);
  initial
  begin
    lvl_o     = 7'h20;
    ext_clk_o = 1'b0;
    osc40_o   = 1'b0;
    oscf_o    = 1'b0;
  end
  task automatic set_lvl(input int b, input logic v);
    @(posedge mclk_i);
    lvl_o[b] <= v;
  endtask
  // one count event; external clock stays high and low three clocks so it is never missed
  task automatic tick(input logic [2:0] src);
    @(posedge mclk_i);
    ext_clk_o <= (src == `SRC_EXT);
    osc40_o   <= (src == `SRC_OSC40);
    oscf_o    <= (src == `SRC_OSCF);
    @(posedge mclk_i);
    osc40_o <= 1'b0;
    oscf_o  <= 1'b0;
    repeat (2) @(posedge mclk_i);
    ext_clk_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// ### testbench/timer_capture_common_logic_tb_top.sv
// self-checking bench for the capture timer
`timescale 1ns/1ns
`default_nettype none
`include "timer_capture_cfg.svh"
module timer_capture_common_logic_tb_top;
  localparam logic [13:0] RT = `BYTE_ADDR(`IDX_ROUTE), OE = `BYTE_ADDR(`IDX_OUTEN), MD = `BYTE_ADDR(`IDX_MODE),
    C1 = `BYTE_ADDR(`IDX_CTRL1), ST = `BYTE_ADDR(`IDX_STATUS), I0 = `BYTE_ADDR(`IDX_IOCTL0),
    I1 = `BYTE_ADDR(`IDX_IOCTL1), CN = `BYTE_ADDR(`IDX_COUNTER), GA = `BYTE_ADDR(`IDX_GEN_A),
    GB = `BYTE_ADDR(`IDX_GEN_B), GC = `BYTE_ADDR(`IDX_GEN_C), GD = `BYTE_ADDR(`IDX_GEN_D),
    FL = `BYTE_ADDR(`IDX_FILTER);
  logic        mclk_i   = 1'b0;
  logic        reset_i  = 1'b1;
  logic        hsel_i   = 1'b0;
  logic [31:0] haddr_i  = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic        fast_en  = 1'b0;
  logic        dir_in   = 1'b0;
  logic        rd_q     = 1'b0;
  logic [31:0] seed     = 32'h35;
  logic [31:0] hrdata_o;
  logic        hreadyout_o, hresp_o, irq_o, ext_clk, osc40, oscf, a_oe, b_oe, a_pin;
  logic [2:0]  c_oe, d_oe;
  logic [6:0]  lvl;
  logic [15:0] b_v, d_v;
  logic [31:0] exp_q[$];
  int          n_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          irqs = 0;
  always #20 mclk_i = ~mclk_i;
  timer_capture_common_logic i_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .chan_a_pin_i(lvl[0]), .chan_a_pin_o(a_pin),
    .chan_a_pin_oe_o(a_oe), .chan_b_pin_i(lvl[1]), .chan_b_pin_o(), .chan_b_pin_oe_o(b_oe),
    .chan_c_pin_i({lvl[2], 2'h0}), .chan_c_pin_o(), .chan_c_pin_oe_o(c_oe), .chan_d_pin_i({2'h0, lvl[3]}),
    .chan_d_pin_o(), .chan_d_pin_oe_o(d_oe), .trigger_pin_i(lvl[6]), .external_count_clock_pin_i(ext_clk),
    .external_count_clock_dir_in_i(dir_in), .cutoff_interrupt_pin_n_i(lvl[5]), .fast_osc_enable_i(fast_en),
    .osc_fast_40m_i(osc40), .osc_fast_divided_i(oscf), .osc_slow_capture_source_i(lvl[4]), .irq_o(irq_o)
  );
  ext_signal_model i_ext (.mclk_i(mclk_i), .lvl_o(lvl), .ext_clk_o(ext_clk), .osc40_o(osc40), .oscf_o(oscf));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // address phase held until hready, then data phase held until hready again
  task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= {18'h0, a};
    hwrite_i <= w;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [13:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // read results are compared in the data-phase cycle where hready returns
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    irqs   <= irqs + int'(irq_o === 1'b1);
    if (rd_q && hreadyout_o === 1'b1)
      chk("hrdata_o", exp_q.pop_front(), hrdata_o);
    if (hsel_i && htrans_i[1] && hreadyout_o)
      rd_q <= !hwrite_i;
    else if (hreadyout_o)
      rd_q <= 1'b0;
    if (cycles == 6000)
    begin
      n_errors++;
      final_report();
    end
  end
  initial
  begin
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    rd(RT, 32'h0);
    rd(OE, 32'h7F);
    rd(GA, 32'hFFFF);
    rd(14'h3FC, 32'h0);
    wr(RT, 32'hFF);
    rd(RT, 32'h77);
    wr(I1, 32'h0);
    wr(OE, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      wr(RT, {26'h0, k[1:0], 2'h0, k[1:0]});
      repeat (3) @(posedge mclk_i);
      chk("chan_c_pin_oe_o", 32'(k == 0 ? 0 : 1 << (k - 1)), {29'h0, c_oe});
      chk("chan_d_pin_oe_o", 32'(k == 0 ? 0 : 1 << (k - 1)), {29'h0, d_oe});
    end
    wr(OE, 32'h80);
    repeat (2) @(posedge mclk_i);
    chk("chan_a_pin_oe_o", 32'h1, {31'h0, a_oe});
    i_ext.set_lvl(5, 1'b0);
    repeat (3) @(posedge mclk_i);
    chk("pin enables", 32'h0, {24'h0, a_oe, b_oe, c_oe, d_oe});
    rd(OE, 32'hFF);
    i_ext.set_lvl(5, 1'b1);
    wr(I0, 32'h4C);
    wr(I1, 32'hCC);
    fast_en <= 1'b1;
    dir_in  <= 1'b1;
    for (int s = 5; s < 8; s++)
    begin
      wr(C1, {25'h0, s[2:0], 4'h0});
      wr(CN, 32'h0);
      wr(MD, 32'h1);
      repeat (4) i_ext.tick(s[2:0]);
      wr(MD, 32'h0);
      rd(CN, 32'h4);
    end
    wr(C1, 32'h0);
    wr(CN, 32'hFFF0);
    wr(MD, 32'h1);
    repeat (20) @(posedge mclk_i);
    wr(MD, 32'h0);
    rd(ST, 32'h80);
    wr(ST, 32'h0);
    wr(MD, 32'h0C);
    wr(FL, 32'h82);
    wr(I0, 32'h44);
    wr(CN, 32'h1234);
    i_ext.set_lvl(4, 1'b1);
    repeat (6) @(posedge mclk_i);
    rd(GA, 32'h1234);
    rd(GC, 32'hFFFF);
    b_v = 16'hFFFF;
    d_v = 16'hFFFF;
    for (int e = 0; e < 3; e++)
    begin
      wr(I0, 32'h44 | (e << 4));
      for (int l = 1; l >= 0; l--)
      begin
        seed = xs(seed);
        wr(CN, {16'h0, seed[15:0]});
        i_ext.set_lvl(1, l[0]);
        repeat (8) @(posedge mclk_i);
        if (e == 2 || e == 1 - l)
        begin
          d_v = b_v;
          b_v = seed[15:0];
        end
        rd(GB, {16'h0, b_v});
        rd(GD, {16'h0, d_v});
      end
    end
    wr(I0, 32'h44);
    i_ext.set_lvl(1, 1'b1);
    i_ext.set_lvl(1, 1'b0);
    repeat (8) @(posedge mclk_i);
    rd(GB, {16'h0, b_v});
    i_ext.set_lvl(2, 1'b1);
    repeat (6) @(posedge mclk_i);
    rd(ST, 32'h07);
    @(posedge mclk_i);
    chk("irq_o pulses", 32'h7, 32'(irqs));
    wr(OE, 32'h0);
    wr(I0, 32'h40);
    wr(I1, 32'h40);
    wr(GA, 32'h10);
    wr(GC, 32'hF);
    wr(ST, 32'h0);
    wr(CN, 32'hE);
    wr(MD, 32'h5);
    repeat (8) @(posedge mclk_i);
    wr(MD, 32'h0);
    rd(GA, 32'hF);
    rd(ST, 32'h5);
    chk("chan_a_pin_o", 32'h3, {30'h0, a_oe, a_pin});
    final_report();
  end
endmodule
`default_nettype wire
